// file: common/irq_defines.svh
// Constants for the shared-vector interrupt logic: register map, field positions, sizes.
// Assumes inclusion by bare name from every file that needs a number.
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

`define ADDR_W 8
`define DATA_W 32
`define REG_CTRL 8'h00
`define REG_ENABLE 8'h04
`define REG_FLAG 8'h08
`define REG_FLAGSET 8'h0C
`define REG_STATUS 8'h10

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CTRL_GIE 0
`define CTRL_SLEEP 1

`define NSRC 4
`define NGRP 2
`define SRC_LOW 0
`define SRC_NV 1
`define SRC_SER 2
`define SRC_SP2 3
`define GRP_LSB 4
`define GRP0_MEMBERS 4'h3
`define GRP1_MEMBERS 4'hC

`define STAT_FULL 0
`define STAT_EMPTY 1
`define STAT_OVF 2
`define STAT_DEPTH_LSB 3
`define STAT_PEND 7

`define PC_W 14
`define STACK_DEPTH 8
`define PTR_W 4

`endif

// file: common/irq_pkg.sv
// Types shared by the interrupt logic: bus channel state encodings.
// Assumes the defines header carries all numeric constants.
package irq_pkg;
	// Write channel progress
	typedef enum logic [1:0] {
		W_IDLE = 2'b00, // Waiting for address and data
		W_TAKE = 2'b01, // Ready raised, handshake this cycle
		W_RESP = 2'b10  // Response offered
	} wr_state_t;
	// Read channel progress
	typedef enum logic [1:0] {
		R_IDLE = 2'b00, // Waiting for address
		R_TAKE = 2'b01, // Ready raised, handshake this cycle
		R_DATA = 2'b10  // Data offered
	} rd_state_t;
endpackage

// file: rtl/level_sync3.sv
// Three-stage synchroniser with agreement filter for one asynchronous level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
module level_sync3 (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic asyncIn, // Level from outside the domain
	output logic syncOut // Filtered level
);
	logic s1_r; // First stage, read only by s2_r
	logic s2_r; // Second stage
	logic s3_r; // Third stage
	logic agree; // Second and third stages match

	assign agree = (s2_r == s3_r);

	// Shift chain; output follows only once two late stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			s1_r <= asyncIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree) begin
				syncOut <= s3_r;
			end
		end
	end
endmodule

// file: rtl/return_stack.sv
// Return address stack holding program counter values only.
// Assumes push and pop are single-cycle strobes; pop wins if both come together.
`timescale 1ns/10ps
`include "irq_defines.svh"
module return_stack (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic push, // Store pushData on top
	input wire logic [`PC_W-1:0] pushData, // Address to save
	input wire logic pop, // Remove top entry
	output logic [`PC_W-1:0] top, // Current top entry
	output logic full, // No room left
	output logic empty, // Nothing stored
	output logic [`PTR_W-1:0] depth, // Entries in use
	output logic overflow // Push refused while full, one cycle
);
	logic [`PC_W-1:0] mem [`STACK_DEPTH]; // Saved addresses
	logic [`PTR_W-1:0] ptr_r; // Next free slot
	logic [`PTR_W-1:0] topIdx; // Index of top entry
	logic doPush; // Accepted push
	logic doPop; // Accepted pop

	assign full = (ptr_r == `PTR_W'(`STACK_DEPTH));
	assign empty = (ptr_r == `PTR_W'(0));
	assign depth = ptr_r;
	assign topIdx = empty ? `PTR_W'(0) : ptr_r - `PTR_W'(1);
	assign top = empty ? `PC_W'(0) : mem[topIdx[2:0]];
	assign doPop = pop & ~empty;
	assign doPush = push & ~pop & ~full;
	// A full stack cannot take a nested call; the entry is lost
	assign overflow = push & ~pop & full;

	// Pointer moves
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_r <= `PTR_W'(0);
		end else if (doPop) begin
			ptr_r <= ptr_r - `PTR_W'(1);
		end else if (doPush) begin
			ptr_r <= ptr_r + `PTR_W'(1);
		end
	end

	// Storage has no reset; empty masks stale contents
	always_ff @(posedge clk) begin
		if (doPush) begin
			mem[ptr_r[2:0]] <= pushData;
		end
	end
endmodule

// file: rtl/shared_vector_interrupt_logic.sv
// Interrupt flags, enables, group vectoring, return stack and wake-up for four sources.
// Assumes peripheral strobes are on clk, the supply monitor level is asynchronous,
// and the core raises one of serviceAck, callPush, retPop, retiPop at a time.
`timescale 1ns/10ps
`include "irq_defines.svh"
module shared_vector_interrupt_logic (
	input wire logic clk, // System clock, 125 MHz
	input wire logic rst, // Async reset, active high
	input wire logic [`ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [`DATA_W-1:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [`ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [`DATA_W-1:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic lowSupplyPin, // Supply monitor level, async, high when low
	input wire logic nvWriteDone, // Data-memory write cycle ended, pulse
	input wire logic serialByteDone, // Serial module byte sent or received, pulse
	input wire logic serialAddrMatch, // Two-wire slave address match, pulse
	input wire logic serialTimeout, // Two-wire bus time-out, pulse
	input wire logic secondPortByteDone, // Second serial port byte done, pulse
	input wire logic [`PC_W-1:0] pcIn, // Program counter to save
	input wire logic serviceAck, // Core enters the offered vector, pulse
	input wire logic callPush, // Core subroutine call, pulse
	input wire logic retPop, // Plain return, pulse
	input wire logic retiPop, // Return with enable, pulse
	output logic intReq, // Vector request to core, level
	output logic intGroup, // Group of the offered vector
	output logic [`PC_W-1:0] returnAddr, // Popped address
	output logic globalEnable, // Global interrupt enable state
	output logic wakeUp // Wake request while sleeping, pulse
);
	// Bus channel state
	irq_pkg::wr_state_t wState_r; // Write channel
	irq_pkg::wr_state_t wState_nxt; // Write channel next
	irq_pkg::rd_state_t rState_r; // Read channel
	irq_pkg::rd_state_t rState_nxt; // Read channel next

	// Software visible state
	logic gie_r; // Global interrupt enable
	logic gie_nxt; // Its next value
	logic sleepMode_r; // Sleep or idle mode indication
	logic [`NSRC-1:0] srcEn_r; // Source enables
	logic [`NGRP-1:0] grpEn_r; // Group enables
	logic [`NSRC-1:0] srcFlag_r; // Source request flags
	logic [`NSRC-1:0] srcFlag_nxt; // Their next value
	logic [`NGRP-1:0] grpFlag_r; // Group request flags
	logic [`NGRP-1:0] grpFlag_nxt; // Their next value
	logic [`NGRP-1:0] gated_r; // Previous gated member level
	logic [`NGRP-1:0] gated; // Enabled members pending, per group
	logic ovfSticky_r; // Stack overflow seen

	// Decoded strokes
	logic wrEn; // Write handshake cycle
	logic lane0; // Low byte written
	logic wrCtrl; // Control register write
	logic wrEnable; // Enable register write
	logic wrFlag; // Flag clear write
	logic wrFlagSet; // Flag set write
	logic wrStatus; // Status clear write
	logic wrMapped; // Write hits a register
	logic rdMapped; // Read hits a register
	logic [`DATA_W-1:0] rdMux; // Selected read word
	logic [7:0] wByte; // Low write byte

	// Event and core strokes
	logic lowSupplySync; // Synchronised supply level
	logic [`NSRC-1:0] srcEvent; // Hardware set per source
	logic [`NSRC-1:0] srcSwSet; // Software set per source
	logic [`NSRC-1:0] srcSwClr; // Software clear per source
	logic [`NSRC-1:0] memberMask [`NGRP]; // Group membership
	logic [`NGRP-1:0] grpReq; // Ready-to-vector groups
	logic svcAccept; // Service taken on an offered vector
	logic stackFull; // Return stack has no room
	logic stackEmpty; // Return stack empty
	logic stackOvf; // Push refused, pulse
	logic [`PTR_W-1:0] stackDepth; // Entries in use
	logic [`PC_W-1:0] stackTop; // Top entry
	logic anyPop; // Either return
	logic [`NSRC+`NGRP-1:0] allFlags; // Every request flag
	logic [`NSRC+`NGRP-1:0] allFlagsPrev_r; // Flags one cycle earlier
	logic anyRise; // Some flag went low to high

	// Supply monitor crosses into clk domain
	level_sync3 uLowSync (
		.clk(clk),
		.rst(rst),
		.asyncIn(lowSupplyPin),
		.syncOut(lowSupplySync)
	);

	// Only the program counter is saved, never working registers
	return_stack uStack (
		.clk(clk),
		.rst(rst),
		.push(svcAccept | callPush),
		.pushData(pcIn),
		.pop(anyPop),
		.top(stackTop),
		.full(stackFull),
		.empty(stackEmpty),
		.depth(stackDepth),
		.overflow(stackOvf)
	);

	// Address decode
	assign wrEn = (wState_r == irq_pkg::W_TAKE);
	assign lane0 = s_axi_wstrb[0];
	assign wByte = s_axi_wdata[7:0];
	assign wrCtrl = wrEn & lane0 & (s_axi_awaddr == `REG_CTRL);
	assign wrEnable = wrEn & lane0 & (s_axi_awaddr == `REG_ENABLE);
	assign wrFlag = wrEn & lane0 & (s_axi_awaddr == `REG_FLAG);
	assign wrFlagSet = wrEn & lane0 & (s_axi_awaddr == `REG_FLAGSET);
	assign wrStatus = wrEn & lane0 & (s_axi_awaddr == `REG_STATUS);
	assign wrMapped = (s_axi_awaddr == `REG_CTRL) | (s_axi_awaddr == `REG_ENABLE) |
		(s_axi_awaddr == `REG_FLAG) | (s_axi_awaddr == `REG_FLAGSET) |
		(s_axi_awaddr == `REG_STATUS);
	assign rdMapped = (s_axi_araddr == `REG_CTRL) | (s_axi_araddr == `REG_ENABLE) |
		(s_axi_araddr == `REG_FLAG) | (s_axi_araddr == `REG_FLAGSET) |
		(s_axi_araddr == `REG_STATUS);

	// Read selection; unlisted bits read zero
	assign rdMux =
		(s_axi_araddr == `REG_CTRL) ? `DATA_W'({sleepMode_r, gie_r}) :
		(s_axi_araddr == `REG_ENABLE) ? `DATA_W'({grpEn_r, srcEn_r}) :
		(s_axi_araddr == `REG_FLAG) ? `DATA_W'({grpFlag_r, srcFlag_r}) :
		(s_axi_araddr == `REG_STATUS) ? `DATA_W'({intReq, stackDepth, ovfSticky_r, stackEmpty, stackFull}) :
		`DATA_W'(0);

	// Hardware events per source
	assign srcEvent[`SRC_LOW] = lowSupplySync;
	assign srcEvent[`SRC_NV] = nvWriteDone;
	assign srcEvent[`SRC_SER] = serialByteDone | serialAddrMatch | serialTimeout;
	assign srcEvent[`SRC_SP2] = secondPortByteDone;
	assign memberMask[0] = `GRP0_MEMBERS;
	assign memberMask[1] = `GRP1_MEMBERS;

	// Source flags: set wins over clear; service never touches them
	genvar i;
	generate
		for (i = 0; i < `NSRC; i++) begin : gSrc
			assign srcSwSet[i] = wrFlagSet & wByte[i];
			assign srcSwClr[i] = wrFlag & wByte[i];
			// Enables play no part, so a disabled source still holds its flag
			assign srcFlag_nxt[i] = srcEvent[i] | srcSwSet[i] | (srcFlag_r[i] & ~srcSwClr[i]);
		end
	endgenerate

	// Group flags rise when an enabled member becomes pending
	genvar g;
	generate
		for (g = 0; g < `NGRP; g++) begin : gGrp
			assign gated[g] = |(srcFlag_r & srcEn_r & memberMask[g]);
			// Service clears only the offered group; a new rise in the same cycle wins
			assign grpFlag_nxt[g] = (gated[g] & ~gated_r[g]) |
				(grpFlag_r[g] & ~(svcAccept & (intGroup == 1'(g))) & ~(wrFlag & wByte[`GRP_LSB+g]));
			// Global, group and stack room all needed; otherwise the flag stays pending
			assign grpReq[g] = gie_r & grpEn_r[g] & grpFlag_r[g] & ~stackFull;
		end
	endgenerate

	// Core strokes
	assign svcAccept = serviceAck & intReq;
	assign anyPop = retPop | retiPop;
	// Entry clears, return-with-enable sets, plain return leaves it as it is
	assign gie_nxt = svcAccept ? 1'b0 :
		retiPop ? 1'b1 :
		wrCtrl ? wByte[`CTRL_GIE] : gie_r;

	// Wake detect over every flag, enable state ignored
	assign allFlags = {grpFlag_r, srcFlag_r};
	assign anyRise = |(allFlags & ~allFlagsPrev_r);

	// Flag, enable and mode registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			srcFlag_r <= `NSRC'(0);
			grpFlag_r <= `NGRP'(0);
			gated_r <= `NGRP'(0);
			gie_r <= 1'b0;
			sleepMode_r <= 1'b0;
			srcEn_r <= `NSRC'(0);
			grpEn_r <= `NGRP'(0);
		end else begin
			srcFlag_r <= srcFlag_nxt;
			grpFlag_r <= grpFlag_nxt;
			gated_r <= gated;
			gie_r <= gie_nxt;
			if (wrCtrl) begin
				sleepMode_r <= wByte[`CTRL_SLEEP];
			end
			if (wrEnable) begin
				srcEn_r <= wByte[`NSRC-1:0];
				grpEn_r <= wByte[`GRP_LSB+`NGRP-1:`GRP_LSB];
			end
		end
	end

	// Overflow is kept for software; nested calls in service code risk it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovfSticky_r <= 1'b0;
		end else begin
			ovfSticky_r <= stackOvf | (ovfSticky_r & ~(wrStatus & wByte[`STAT_OVF]));
		end
	end

	// Vector offer; dropped right after acceptance so it is taken once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			intReq <= 1'b0;
			intGroup <= 1'b0;
		end else begin
			intReq <= (|grpReq) & ~svcAccept;
			if (!svcAccept) begin
				// Lower group wins when both are ready
				intGroup <= ~grpReq[0];
			end
		end
	end

	// Popped address, global enable mirror and wake pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			returnAddr <= `PC_W'(0);
			globalEnable <= 1'b0;
			wakeUp <= 1'b0;
			allFlagsPrev_r <= (`NSRC+`NGRP)'(0);
		end else begin
			if (anyPop) begin
				returnAddr <= stackTop;
			end
			globalEnable <= gie_nxt;
			wakeUp <= sleepMode_r & anyRise;
			allFlagsPrev_r <= allFlags;
		end
	end

	// Write channel: both address and data needed before ready rises
	always_comb begin
		wState_nxt = wState_r;
		case (wState_r)
			irq_pkg::W_IDLE: begin
				if (s_axi_awvalid && s_axi_wvalid) begin
					wState_nxt = irq_pkg::W_TAKE;
				end
			end
			irq_pkg::W_TAKE: begin
				wState_nxt = irq_pkg::W_RESP;
			end
			irq_pkg::W_RESP: begin
				if (s_axi_bready) begin
					wState_nxt = irq_pkg::W_IDLE;
				end
			end
			default: begin
				wState_nxt = irq_pkg::W_IDLE;
			end
		endcase
	end

	// Write channel outputs registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wState_r <= irq_pkg::W_IDLE;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			wState_r <= wState_nxt;
			s_axi_awready <= (wState_nxt == irq_pkg::W_TAKE);
			s_axi_wready <= (wState_nxt == irq_pkg::W_TAKE);
			s_axi_bvalid <= (wState_nxt == irq_pkg::W_RESP);
			if (wrEn) begin
				s_axi_bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// Read channel sequencing
	always_comb begin
		rState_nxt = rState_r;
		case (rState_r)
			irq_pkg::R_IDLE: begin
				if (s_axi_arvalid) begin
					rState_nxt = irq_pkg::R_TAKE;
				end
			end
			irq_pkg::R_TAKE: begin
				rState_nxt = irq_pkg::R_DATA;
			end
			irq_pkg::R_DATA: begin
				if (s_axi_rready) begin
					rState_nxt = irq_pkg::R_IDLE;
				end
			end
			default: begin
				rState_nxt = irq_pkg::R_IDLE;
			end
		endcase
	end

	// Read channel outputs; data captured at the address handshake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rState_r <= irq_pkg::R_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `DATA_W'(0);
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			rState_r <= rState_nxt;
			s_axi_arready <= (rState_nxt == irq_pkg::R_TAKE);
			s_axi_rvalid <= (rState_nxt == irq_pkg::R_DATA);
			if (rState_r == irq_pkg::R_TAKE) begin
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end
endmodule

// file: sim/core_model.sv
// Behavioural core: takes offered vectors, issues calls and returns on request.
// Assumes the bench calls one task at a time.
`timescale 1ns/10ps
`include "irq_defines.svh"
module core_model (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset
	input wire logic intReq, // Vector offered
	input wire logic intGroup, // Group offered
	output logic serviceAck, // Vector taken, pulse
	output logic [`PC_W-1:0] pcIn, // Address to save
	output logic callPush, // Call, pulse
	output logic retPop, // Plain return, pulse
	output logic retiPop // Return with enable, pulse
);
	int ackDelay = 2; // Cycles before taking, prompt or slow
	int waited = 0; // Cycles the offer stood
	int ackCnt = 0; // Vectors taken
	logic grpSeen = 1'b0; // Group of last vector
	initial begin
		serviceAck = 1'b0;
		pcIn = 14'h0000;
		callPush = 1'b0;
		retPop = 1'b0;
		retiPop = 1'b0;
	end
	// Vector taking; a late core only delays, never refuses
	always @(posedge clk) begin
		if (serviceAck && intReq) begin
			ackCnt <= ackCnt + 1;
			grpSeen <= intGroup;
		end
		if (!rst && intReq && !serviceAck && waited >= ackDelay) begin
			serviceAck <= 1'b1;
			waited <= 0;
		end else begin
			serviceAck <= 1'b0;
			waited <= (intReq && !serviceAck) ? waited + 1 : 0;
		end
	end
	// Address the next service saves
	task automatic load(input logic [`PC_W-1:0] pc);
		pcIn <= pc;
	endtask
	// Calls only outside service code
	task automatic strobe(input int kind, input logic [`PC_W-1:0] pc);
		@(posedge clk);
		if (kind == 0)
			pcIn <= pc;
		callPush <= (kind == 0);
		retPop <= (kind == 1);
		retiPop <= (kind == 2);
		@(posedge clk);
		callPush <= 1'b0;
		retPop <= 1'b0;
		retiPop <= 1'b0;
		@(posedge clk);
	endtask
endmodule

// file: sim/irq_props.sv
// Checker for the interrupt logic: bus answer timing, vectoring, service and returns.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`include "irq_defines.svh"
module irq_props (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_wready, // Write data ready
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic s_axi_arready, // Read address ready
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic serviceAck, // Core takes vector
	input wire logic retPop, // Plain return
	input wire logic retiPop, // Return with enable
	input wire logic intReq, // Vector offered
	input wire logic [`PC_W-1:0] returnAddr, // Popped address
	input wire logic globalEnable // Global enable
);
	// One domain; reset silences everything
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Service drops the offer and the global enable
	property p_serviceClears;
		serviceAck && intReq |=> !intReq && !globalEnable;
	endproperty
	a_serviceClears: assert property (p_serviceClears)
		else $error("service left request or enable set");
	// No offer unless the global enable stood the cycle before
	property p_reqNeedsGlobal;
		intReq |-> $past(globalEnable);
	endproperty
	a_reqNeedsGlobal: assert property (p_reqNeedsGlobal)
		else $error("vector offered without global enable");
	// Return with enable raises the enable
	property p_retiSets;
		retiPop && !(serviceAck && intReq) |=> globalEnable;
	endproperty
	a_retiSets: assert property (p_retiSets)
		else $error("return with enable left enable low");
	// Plain return leaves a low enable low
	property p_retKeeps;
		retPop && !globalEnable && !s_axi_awready |=> !globalEnable;
	endproperty
	a_retKeeps: assert property (p_retKeeps)
		else $error("plain return raised the enable");
	// Enable falls only by service or a register write
	property p_enableFalls;
		$fell(globalEnable) |-> ($past(serviceAck) && $past(intReq)) || $past(s_axi_awready);
	endproperty
	a_enableFalls: assert property (p_enableFalls)
		else $error("enable fell without cause");
	// Address stands between pops
	property p_addrHolds;
		!retPop && !retiPop |=> $stable(returnAddr);
	endproperty
	a_addrHolds: assert property (p_addrHolds)
		else $error("return address moved without a pop");
	// Write readies come as a pair
	property p_readyPair;
		s_axi_awready |-> s_axi_wready;
	endproperty
	a_readyPair: assert property (p_readyPair)
		else $error("write readies split");
	// Write answered the cycle after the handshake
	property p_writeAnswer;
		s_axi_awready |=> s_axi_bvalid && !s_axi_awready;
	endproperty
	a_writeAnswer: assert property (p_writeAnswer)
		else $error("write response late");
	// Response leaves once taken
	property p_bDone;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bDone: assert property (p_bDone)
		else $error("write response stayed");
	// Read answered the cycle after the handshake
	property p_readAnswer;
		s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_readAnswer: assert property (p_readAnswer)
		else $error("read data late");
endmodule
bind shared_vector_interrupt_logic irq_props u_props (.clk, .rst, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .serviceAck, .retPop, .retiPop,
	.intReq, .returnAddr, .globalEnable);

// file: sim/tb.sv
// Self-checking bench for the shared-vector interrupt logic.
// Assumes the core model beside the design and the bound checker.
`timescale 1ns/10ps
`include "irq_defines.svh"
module tb;
	logic clk = 1'b0; // 125 MHz clock
	logic rst = 1'b1; // Reset, active high
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00; // Bus addresses
	logic [31:0] wData = 32'h00000000; // Write data
	logic [3:0] wStrb = 4'hF; // Byte enables
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0; // Handshakes
	logic lowPin = 1'b0; // Supply monitor level
	logic [4:0] pulses = 5'h00; // Nv, byte, match, timeout, second port
	logic awReady, wReady, bValid, arReady, rValid, intReq, intGroup, globalEnable, wakeUp; // Outputs
	logic [1:0] bResp, rResp; // Responses
	logic [31:0] rData; // Read data
	logic [`PC_W-1:0] returnAddr, pcIn; // Stack traffic
	logic serviceAck, callPush, retPop, retiPop; // Core strobes
	int nFail = 0, checked = 0, cycles = 0, wakes = 0; // Counters
	int seed = 28; // Random seed
	logic [`PC_W-1:0] stackQ[$]; // Expected return stack
	shared_vector_interrupt_logic u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .lowSupplyPin(lowPin),
		.nvWriteDone(pulses[0]), .serialByteDone(pulses[1]), .serialAddrMatch(pulses[2]),
		.serialTimeout(pulses[3]), .secondPortByteDone(pulses[4]), .pcIn(pcIn), .serviceAck(serviceAck),
		.callPush(callPush), .retPop(retPop), .retiPop(retiPop), .intReq(intReq), .intGroup(intGroup),
		.returnAddr(returnAddr), .globalEnable(globalEnable), .wakeUp(wakeUp));
	core_model u_core (.clk(clk), .rst(rst), .intReq(intReq), .intGroup(intGroup), .serviceAck(serviceAck),
		.pcIn(pcIn), .callPush(callPush), .retPop(retPop), .retiPop(retiPop));
	always #4 clk = ~clk;
	// Watchdog and wake pulse count
	always @(posedge clk) begin
		cycles++;
		if (wakeUp)
			wakes++;
		if (cycles > 8000) begin
			nFail++;
			stopTest();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			nFail++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// Write with both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		@(posedge clk);
		while (!awReady) @(posedge clk);
		awValid <= 1'b0;
		wValid <= 1'b0;
		while (!bValid) @(posedge clk);
		bReady <= 1'b0;
		chk(32'(bResp), 32'(er));
	endtask
	// Read and compare data and response
	task automatic rdChk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		@(posedge clk);
		while (!arReady) @(posedge clk);
		arValid <= 1'b0;
		while (!rValid) @(posedge clk);
		rReady <= 1'b0;
		chk(rData, ed);
		chk(32'(rResp), 32'(er));
	endtask
	// Event 0 holds the supply pin high; others pulse one cycle
	task automatic fire(input int ev);
		@(posedge clk);
		if (ev == 0)
			lowPin <= 1'b1;
		else
			pulses <= 5'h01 << (ev - 1);
		@(posedge clk);
		pulses <= 5'h00;
	endtask
	// Bounded wait for one more vector taken
	task automatic waitAck(input int n);
		int t;
		t = 0;
		while (u_core.ackCnt == n && t < 60) begin
			@(posedge clk);
			t++;
		end
		chk(32'(u_core.ackCnt), 32'(n + 1));
	endtask
	task automatic stopTest();
		$display("checked %0d n_fail %0d", checked, nFail);
		if (nFail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		int ev, src, grp, n;
		logic [31:0] tmp;
		logic [`PC_W-1:0] e;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// Reset values, unmapped places
		rdChk(`REG_CTRL, 32'h00000000, `RESP_OKAY);
		rdChk(`REG_ENABLE, 32'h00000000, `RESP_OKAY);
		rdChk(`REG_STATUS, 32'h00000002, `RESP_OKAY);
		rdChk(8'h20, 32'h00000000, `RESP_SLVERR);
		// Low lane off: accepted but nothing written
		wStrb <= 4'hE;
		wr(`REG_CTRL, 32'h00000001, `RESP_OKAY);
		wStrb <= 4'hF;
		rdChk(`REG_CTRL, 32'h00000000, `RESP_OKAY);
		wr(8'h24, 32'h00000001, `RESP_SLVERR);
		// Disabled source still flags; enabling forms the group
		fire(1);
		rdChk(`REG_FLAG, 32'h00000002, `RESP_OKAY);
		wr(`REG_ENABLE, 32'h00000012, `RESP_OKAY);
		rdChk(`REG_FLAG, 32'h00000012, `RESP_OKAY);
		// Overfill the stack, then enable: offer must wait
		for (n = 0; n < 9; n++) begin
			tmp = $random(seed);
			u_core.strobe(0, tmp[`PC_W-1:0]);
			if (stackQ.size() < `STACK_DEPTH)
				stackQ.push_back(tmp[`PC_W-1:0]);
		end
		rdChk(`REG_STATUS, 32'h00000045, `RESP_OKAY);
		wr(`REG_STATUS, 32'h00000004, `RESP_OKAY);
		tmp = $random(seed);
		u_core.load(tmp[`PC_W-1:0]);
		wr(`REG_CTRL, 32'h00000001, `RESP_OKAY);
		repeat (6) @(posedge clk);
		chk(32'(intReq), 32'h00000000);
		rdChk(`REG_STATUS, 32'h00000041, `RESP_OKAY);
		n = u_core.ackCnt;
		u_core.strobe(1, 14'h0000);
		chk(32'(returnAddr), 32'(stackQ.pop_back()));
		waitAck(n);
		stackQ.push_back(tmp[`PC_W-1:0]);
		chk(32'(globalEnable), 32'h00000000);
		rdChk(`REG_FLAG, 32'h00000002, `RESP_OKAY);
		// Plain returns keep the enable low; the last finds the stack empty
		for (n = 0; n < 9; n++) begin
			u_core.strobe(1, 14'h0000);
			e = stackQ.size() > 0 ? stackQ.pop_back() : 14'h0000;
			chk(32'(returnAddr), 32'(e));
			chk(32'(globalEnable), 32'h00000000);
		end
		wr(`REG_FLAG, 32'h0000003F, `RESP_OKAY);
		// Every event kind through its group, prompt and slow core
		for (ev = 0; ev < 6; ev++) begin
			src = ev == 0 ? 0 : ev == 5 ? 3 : ev > 1 ? 2 : 1;
			grp = src / 2;
			u_core.ackDelay = (ev % 3) * 3;
			tmp = $random(seed);
			u_core.load(tmp[`PC_W-1:0]);
			wr(`REG_ENABLE, (32'h1 << src) | (32'h10 << grp), `RESP_OKAY);
			rdChk(`REG_ENABLE, (32'h1 << src) | (32'h10 << grp), `RESP_OKAY);
			wr(`REG_CTRL, 32'h00000001, `RESP_OKAY);
			n = u_core.ackCnt;
			fire(ev);
			waitAck(n);
			chk(32'(u_core.grpSeen), 32'(grp));
			chk(32'(globalEnable), 32'h00000000);
			rdChk(`REG_FLAG, 32'h1 << src, `RESP_OKAY);
			rdChk(`REG_STATUS, 32'h00000008, `RESP_OKAY);
			u_core.strobe(2, 14'h0000);
			chk(32'(returnAddr), 32'(tmp[`PC_W-1:0]));
			chk(32'(globalEnable), 32'h00000001);
			lowPin <= 1'b0;
			repeat (8) @(posedge clk);
			wr(`REG_FLAG, 32'h1 << src, `RESP_OKAY);
			rdChk(`REG_FLAG, 32'h00000000, `RESP_OKAY);
		end
		// Sleeping with all enables off; a preset flag must not wake
		wr(`REG_ENABLE, 32'h00000000, `RESP_OKAY);
		wr(`REG_FLAGSET, 32'h00000004, `RESP_OKAY);
		wr(`REG_CTRL, 32'h00000002, `RESP_OKAY);
		for (n = 0; n < 3; n++) begin
			wakes = 0;
			// Later passes find the flag already set by hardware or software
			fire(n == 2 ? 2 : 5);
			repeat (6) @(posedge clk);
			chk(32'(wakes), n == 0 ? 32'h00000001 : 32'h00000000);
		end
		stopTest();
	end
endmodule
